// ==== hw/umlsc_modem_mon.sv ====
`timescale 1ns/1ns
module umlsc_modem_mon
(
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic [3:0] state_in,
    input  wire logic       clear,
    output logic      [3:0] state_q,
    output logic      [3:0] delta_q
);
    import umlsc_pkg::*;

    // order: cts, set-ready, ring, carrier (active high)
    wire [3:0] set_ev;

    assign set_ev[0] = state_in[0] ^ state_q[0];   // RULE20
    assign set_ev[1] = state_in[1] ^ state_q[1];   // RULE20
    assign set_ev[2] = state_q[2] & ~state_in[2];  // RULE21
    assign set_ev[3] = state_in[3] ^ state_q[3];   // RULE20

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= 4'h0;
            delta_q <= 4'h0;
        end
        else
        begin
            state_q <= state_in;
            // a change in the clearing cycle is kept
            delta_q <= (delta_q & ~{4{clear}}) | set_ev; // RULE26
        end
    end
endmodule : umlsc_modem_mon

// ==== hw/umlsc_prescale.sv ====
`timescale 1ns/1ns
module umlsc_prescale
(
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic div4,
    output logic      tick_q
);
    import umlsc_pkg::*;

    logic [1:0] cnt_q;
    wire        wrap = (cnt_q == PRESC_MAX);

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_q  <= 2'h0;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= div4 ? cnt_q + 2'h1 : 2'h0; // RULE11
            tick_q <= div4 ? wrap : 1'b1;         // RULE11
        end
    end
endmodule : umlsc_prescale

// ==== hw/umlsc_top.sv ====
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ns
module umlsc_top
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    // avalon-mm slave, byte address
    input  wire logic [5:0]  address,
    input  wire logic [3:0]  byteenable,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // modem pins
    input  wire logic        cts_in_n,
    input  wire logic        set_ready_in_n,
    input  wire logic        bell_indicator_in_n,
    input  wire logic        carrier_detect_in_n,
    output logic             term_ready_out_n,
    output logic             req_send_out_n,
    // request-to-send owners outside this block
    input  wire logic        auto_rts_n,
    input  wire logic        half_duplex_en,
    input  wire logic        half_duplex_n,
    // receiver side
    input  wire logic        fifo_mode,
    input  wire logic        rx_char_valid,
    input  wire logic [7:0]  rx_char_data,
    input  wire logic        rx_char_parity_err,
    input  wire logic        rx_char_frame_err,
    input  wire logic        rx_char_break,
    input  wire logic        rx_char_xonoff,
    input  wire logic        sw_flow_active,
    input  wire logic        rx_fifo_full,
    input  wire logic        rx_fifo_nonempty,
    input  wire logic [7:0]  rx_head_data,
    input  wire logic        rx_head_parity_err,
    input  wire logic        rx_head_frame_err,
    input  wire logic        rx_head_break,
    output logic             rx_push,
    output logic      [7:0]  rx_push_data,
    output logic      [2:0]  rx_push_err,
    output logic             rx_pop,
    // transmitter side
    input  wire logic        tx_fifo_empty,
    input  wire logic        tx_xfer,
    input  wire logic        tx_shift_busy,
    output logic             tx_load,
    output logic      [7:0]  tx_load_data,
    output logic             tx_halt,
    output logic             xon_any_resume,
    // configuration to neighbouring blocks
    output logic      [7:0]  line_format,
    output logic      [15:0] divisor,
    output logic      [7:0]  flow_threshold,
    output logic      [7:0]  fifo_trigger,
    output logic             ir_mode,
    output logic             loopback,
    output logic             baud_tick,
    output logic             modem_irq_req
);
    import umlsc_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // registers

    umlsc_bus_e  bus_q;
    logic [7:0]  lfmt_q;
    logic [7:0]  mctl_q;
    logic [7:0]  enh_q;
    logic [7:0]  irqen_q;
    logic [7:0]  div_lo_q;
    logic [7:0]  div_hi_q;
    logic [7:0]  scr_q;
    logic [7:0]  thr_q;
    logic [7:0]  trig_q;
    logic        overrun_q;
    logic        thre_q;
    logic        brk_hold_q;
    logic [6:0]  err_cnt_q;
    logic [31:0] rdata_q;
    logic        wait_q;
    logic        push_q;
    logic [7:0]  push_data_q;
    logic [2:0]  push_err_q;
    logic        pop_q;
    logic        load_q;
    logic [7:0]  load_data_q;
    logic        halt_q;
    logic        resume_q;
    logic        trdy_n_q;
    logic        rts_n_q;
    logic        irq_q;
    logic [3:0]  mstate;
    logic [3:0]  mdelta;
    logic        tick;

    ////////////////////////////////////////////////////////////////////
    // decode

    // upper page at 6/7 needs both the enhanced bit and control bit 2
    function automatic logic upper_page(input logic [7:0] enh,
                                        input logic [7:0] mctl);
        upper_page = enh[EN_ENH] & mctl[MC_SPARE1];
    endfunction : upper_page

    wire [3:0] idx      = address[5:2];
    wire       in_range = (address[1:0] == 2'b00);
    wire       acc      = bus_q == UMLSC_ACK;
    wire       wr_acc   = acc & write & byteenable[0] & in_range;
    wire       rd_acc   = acc & read & in_range;
    wire [7:0] wd       = writedata[7:0];
    wire       div_sel  = lfmt_q[LF_DIV];                  // RULE1
    wire       page_up  = upper_page(enh_q, mctl_q);       // RULE4
    wire       lb       = mctl_q[MC_LOOP];                 // RULE7

    wire wr_data  = wr_acc & (idx == IDX_DATA) & ~div_sel; // RULE1
    wire wr_dlo   = wr_acc & (idx == IDX_DATA) & div_sel;  // RULE1
    wire wr_dhi   = wr_acc & (idx == IDX_DIVH) & div_sel;  // RULE1
    wire wr_ien   = wr_acc & (idx == IDX_DIVH) & ~div_sel;
    wire wr_lfmt  = wr_acc & (idx == IDX_LFMT);
    wire wr_mctl  = wr_acc & (idx == IDX_MCTL);
    wire wr_enh   = wr_acc & (idx == IDX_ENH);
    wire wr_thr   = wr_acc & (idx == IDX_MST) & page_up;   // RULE4
    wire wr_scr   = wr_acc & (idx == IDX_SCR) & ~page_up;  // RULE4
    wire wr_trig  = wr_acc & (idx == IDX_SCR) & page_up;   // RULE4
    wire rd_data  = rd_acc & (idx == IDX_DATA) & ~div_sel;
    wire rd_lst   = rd_acc & (idx == IDX_LST);
    wire rd_mst   = rd_acc & (idx == IDX_MST) & ~page_up;  // RULE26

    // bits 7:5 keep their value without the enhanced bit
    wire [7:0] mctl_keep = enh_q[EN_ENH] ? 8'h00 : MC_LOCKED;
    wire [7:0] mctl_d    = (wd & ~mctl_keep) | (mctl_q & mctl_keep); // RULE9

    ////////////////////////////////////////////////////////////////////
    // modem lines

    // loopback feeds control bits back as active-high states
    wire [3:0] pin_state = {~carrier_detect_in_n, ~bell_indicator_in_n,
                            ~set_ready_in_n, ~cts_in_n};
    wire [3:0] lb_state  = {mctl_q[MC_SPARE2], mctl_q[MC_SPARE1],
                            mctl_q[MC_TRDY], mctl_q[MC_RTS]}; // RULE5
    wire [3:0] mon_in    = lb ? lb_state : pin_state;     // RULE27

    umlsc_modem_mon u_mon
    (
        .clk      (clk),
        .arst_n   (arst_n),
        .state_in (mon_in),
        .clear    (rd_mst),
        .state_q  (mstate),
        .delta_q  (mdelta)
    );

    umlsc_prescale u_presc
    (
        .clk    (clk),
        .arst_n (arst_n),
        .div4   (mctl_q[MC_PRESC]),
        .tick_q (tick)
    );

    // spare outputs have no pin; they only reach the loopback path
    wire spare_one_n = ~mctl_q[MC_SPARE1]; // RULE6
    wire spare_two_n = ~mctl_q[MC_SPARE2]; // RULE6

    // pins park inactive (high) while looped back
    wire trdy_n_d = lb | ~mctl_q[MC_TRDY];                  // RULE2
    wire rts_own  = half_duplex_en ? half_duplex_n : auto_rts_n;
    wire rts_man  = ~mctl_q[MC_RTS];
    wire rts_ext  = half_duplex_en | enh_q[EN_ARTS];
    wire rts_n_d  = lb | (rts_ext ? rts_own : rts_man);     // RULE3

    // halt only gates the next start; the core finishes its frame
    wire halt_d   = enh_q[EN_ACTS] & ~mstate[0];            // RULE22

    ////////////////////////////////////////////////////////////////////
    // receive line status

    wire char_err  = rx_char_parity_err | rx_char_frame_err | rx_char_break;
    wire ovr_ev    = rx_char_valid & rx_fifo_full;          // RULE13
    wire dup_brk   = rx_char_break & brk_hold_q;            // RULE16
    wire flow_char = rx_char_xonoff & sw_flow_active & mctl_q[MC_XANY];
    wire push_d    = rx_char_valid & ~rx_fifo_full & ~dup_brk
                     & ~flow_char;                          // RULE8
    wire head_err  = rx_head_parity_err | rx_head_frame_err | rx_head_break;
    wire err_inc   = push_d & char_err;
    wire err_dec   = pop_q & head_err & (err_cnt_q != 7'h00);
    wire resume_d  = rx_char_valid & mctl_q[MC_XANY];       // RULE8

    wire thre_now  = fifo_mode ? tx_fifo_empty : thre_q;    // RULE17

    wire [7:0] lst;
    assign lst[0] = rx_fifo_nonempty;                       // RULE12
    assign lst[1] = overrun_q;                              // RULE13
    assign lst[2] = rx_fifo_nonempty & rx_head_parity_err;  // RULE14
    assign lst[3] = rx_fifo_nonempty & rx_head_frame_err;   // RULE15
    assign lst[4] = rx_fifo_nonempty & rx_head_break;       // RULE16
    assign lst[5] = thre_now;                               // RULE17
    assign lst[6] = thre_now & ~tx_shift_busy;              // RULE18
    assign lst[7] = err_cnt_q != 7'h00;                     // RULE19

    // bits 7:4 state, 3:0 change flags
    wire [7:0] mst = {mstate, mdelta};                      // RULE23 RULE25

    ////////////////////////////////////////////////////////////////////
    // read mux

    wire [7:0] rd_byte =
        (idx == IDX_DATA) ? (div_sel ? div_lo_q : rx_head_data) :
        (idx == IDX_DIVH) ? (div_sel ? div_hi_q : irqen_q) :
        (idx == IDX_LFMT) ? lfmt_q :
        (idx == IDX_MCTL) ? mctl_q :
        (idx == IDX_LST)  ? lst :
        (idx == IDX_MST)  ? (page_up ? thr_q : mst) :       // RULE24
        (idx == IDX_SCR)  ? (page_up ? trig_q : scr_q) :
        (idx == IDX_ENH)  ? enh_q : 8'h00;
    wire [31:0] rd_word = in_range ? {24'h00_0000, rd_byte} : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////
    // bus handshake: one wait cycle, accept on the second edge

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bus_q   <= UMLSC_IDLE;
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            case (bus_q)
                UMLSC_IDLE:
                begin
                    if (read | write)
                    begin
                        bus_q   <= UMLSC_ACK;
                        wait_q  <= 1'b0;
                        rdata_q <= read ? rd_word : 32'h0000_0000;
                    end
                end
                UMLSC_ACK:
                begin
                    bus_q  <= UMLSC_IDLE;
                    wait_q <= 1'b1;
                end
                default:
                begin
                    bus_q  <= UMLSC_IDLE;
                    wait_q <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // software registers

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lfmt_q   <= LFMT_RST;
            mctl_q   <= ZERO_RST;
            enh_q    <= ZERO_RST;
            irqen_q  <= ZERO_RST;
            div_lo_q <= ZERO_RST;
            div_hi_q <= ZERO_RST;
            scr_q    <= SCR_RST;
            thr_q    <= ZERO_RST;
            trig_q   <= ZERO_RST;
        end
        else
        begin
            if (wr_lfmt) lfmt_q <= wd;
            if (wr_mctl) mctl_q <= mctl_d;                  // RULE9
            if (wr_enh) enh_q <= wd;
            if (wr_ien) irqen_q <= wd;
            if (wr_dlo) div_lo_q <= wd;
            if (wr_dhi) div_hi_q <= wd;
            if (wr_scr) scr_q <= wd;
            if (wr_thr) thr_q <= wd;
            if (wr_trig) trig_q <= wd;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // status flags and datapath strobes

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            overrun_q  <= 1'b0;
            thre_q     <= 1'b1;
            brk_hold_q <= 1'b0;
            err_cnt_q  <= 7'h00;
        end
        else
        begin
            // hardware set beats a read clear in the same cycle
            overrun_q <= (overrun_q & ~rd_lst) | ovr_ev;    // RULE13
            thre_q    <= (thre_q & ~wr_data) | tx_xfer;     // RULE17
            if (rx_char_valid)
                brk_hold_q <= rx_char_break;                // RULE16
            err_cnt_q <= err_cnt_q + {6'h00, err_inc}
                         - {6'h00, err_dec};                // RULE19
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            push_q      <= 1'b0;
            push_data_q <= 8'h00;
            push_err_q  <= 3'h0;
            pop_q       <= 1'b0;
            load_q      <= 1'b0;
            load_data_q <= 8'h00;
            halt_q      <= 1'b0;
            resume_q    <= 1'b0;
            trdy_n_q    <= 1'b1;
            rts_n_q     <= 1'b1;
            irq_q       <= 1'b0;
        end
        else
        begin
            push_q      <= push_d;
            push_data_q <= rx_char_data;
            push_err_q  <= {rx_char_break, rx_char_frame_err,
                            rx_char_parity_err};
            pop_q       <= rd_data;
            load_q      <= wr_data;
            load_data_q <= wr_data ? wd : load_data_q;
            halt_q      <= halt_d;                          // RULE22
            resume_q    <= resume_d;                        // RULE8
            trdy_n_q    <= trdy_n_d;                        // RULE2
            rts_n_q     <= rts_n_d;                         // RULE3
            irq_q       <= irqen_q[IE_MODEM] & (|mdelta);   // RULE20
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    assign readdata       = rdata_q;
    assign waitrequest    = wait_q;
    assign term_ready_out_n = trdy_n_q;
    assign req_send_out_n = rts_n_q;
    assign rx_push        = push_q;
    assign rx_push_data   = push_data_q;
    assign rx_push_err    = push_err_q;
    assign rx_pop         = pop_q;
    assign tx_load        = load_q;
    assign tx_load_data   = load_data_q;
    assign tx_halt        = halt_q;
    assign xon_any_resume = resume_q;
    assign line_format    = lfmt_q;
    assign divisor        = {div_hi_q, div_lo_q};
    assign flow_threshold = thr_q;
    assign fifo_trigger   = trig_q;
    assign ir_mode        = mctl_q[MC_IR];                  // RULE10
    assign loopback       = mctl_q[MC_LOOP];                // RULE7
    assign baud_tick      = tick;                           // RULE11
    assign modem_irq_req  = irq_q;

    // spare outputs are visible in the modem state during loopback
    wire unused_ok = spare_one_n & spare_two_n;
endmodule : umlsc_top

// ==== inc/umlsc_pkg.sv ====
// Summary of operation
// RULE1: divisor-access bit maps divisor registers over data
// RULE2: control bit 0 drives terminal-ready low
// RULE3: control bit 1 drives request-to-send unless owned
// RULE4: offsets 6/7 page to threshold/trigger when enabled
// RULE5: loopback ring-indicator comes from control bit 2
// RULE6: control bit 3 drives internal spare output low
// RULE7: control bit 4 enables internal loopback
// RULE8: xon-any resumes transmit on any received character
// RULE9: control bits 7:5 writable only with enhanced bit
// RULE10: control bit 6 enables infrared mode
// RULE11: control bit 7 divides clock by four
// RULE12: line bit 0 shows received data waiting
// RULE13: full receive fifo sets overrun, drops character
// RULE14: parity flag follows the head character
// RULE15: framing flag follows the head character
// RULE16: break flagged, only one break char stored
// RULE17: holding-empty flag tracks holding register or fifo
// RULE18: idle flag needs holding and shift empty
// RULE19: fifo error flag while any errored byte remains
// RULE20: change flags for cts, set-ready, carrier detect
// RULE21: ring change flag only at end of ringing
// RULE22: auto clear-to-send high pauses transmit
// RULE23: state bit 4 is inverted cts or rts bit
// RULE24: state bits 5,6 inverted inputs or loopback bits
// RULE25: state bit 7 inverted carrier or control bit 3
// RULE26: reading modem state clears change flags
// RULE27: loopback disconnects outputs, routes them internally
package umlsc_pkg;
    // register indices; byte address is four times the index
    localparam logic [3:0] IDX_DATA = 4'h0;
    localparam logic [3:0] IDX_DIVH = 4'h1;
    localparam logic [3:0] IDX_LFMT = 4'h3;
    localparam logic [3:0] IDX_MCTL = 4'h4;
    localparam logic [3:0] IDX_LST  = 4'h5;
    localparam logic [3:0] IDX_MST  = 4'h6;
    localparam logic [3:0] IDX_SCR  = 4'h7;
    localparam logic [3:0] IDX_ENH  = 4'h8;

    localparam int LF_DIV     = 7;
    localparam int MC_TRDY    = 0;
    localparam int MC_RTS     = 1;
    localparam int MC_SPARE1  = 2;
    localparam int MC_SPARE2  = 3;
    localparam int MC_LOOP    = 4;
    localparam int MC_XANY    = 5;
    localparam int MC_IR      = 6;
    localparam int MC_PRESC   = 7;
    localparam int EN_ENH     = 4;
    localparam int EN_ARTS    = 6;
    localparam int EN_ACTS    = 7;
    localparam int IE_MODEM   = 3;

    localparam logic [7:0] LFMT_RST  = 8'h1D;
    localparam logic [7:0] SCR_RST   = 8'hFF;
    localparam logic [7:0] ZERO_RST  = 8'h00;
    localparam logic [7:0] MC_LOCKED = 8'hE0;
    localparam logic [1:0] PRESC_MAX = 2'h3;

    typedef enum logic [1:0]
    {
        UMLSC_IDLE = 2'b01,
        UMLSC_ACK  = 2'b10
    } umlsc_bus_e;
endpackage : umlsc_pkg

// ==== verif/tb.sv ====
`timescale 1ns/1ns
module tb;
    logic clk = 1'b0, arst_n = 1'b0, read = 1'b0, write = 1'b0, slow = 1'b0;
    logic [5:0] address = '0;
    logic [3:0] byteenable = '0, want = '0;
    logic [31:0] writedata = '0, readdata;
    logic waitrequest, cts_in_n, set_ready_in_n, bell_indicator_in_n;
    logic carrier_detect_in_n, term_ready_out_n, req_send_out_n;
    logic auto_rts_n = 1'b1, half_duplex_en = 1'b0, half_duplex_n = 1'b1;
    logic fifo_mode = 1'b1, rx_char_valid = 1'b0, rx_char_parity_err = 1'b0;
    logic rx_char_frame_err = 1'b0, rx_char_break = 1'b0;
    logic rx_char_xonoff = 1'b0, sw_flow_active = 1'b0, rx_fifo_full = 1'b0;
    logic rx_fifo_nonempty = 1'b0, rx_head_parity_err = 1'b0;
    logic rx_head_frame_err = 1'b0, rx_head_break = 1'b0;
    logic tx_fifo_empty = 1'b1, tx_xfer = 1'b0, tx_shift_busy = 1'b0;
    logic [7:0] rx_char_data = '0, rx_head_data = '0, r, dd;
    logic rx_push, rx_pop, tx_load, tx_halt, xon_any_resume, ir_mode;
    logic loopback, baud_tick, modem_irq_req;
    logic [7:0] rx_push_data, tx_load_data, line_format, flow_threshold;
    logic [7:0] fifo_trigger;
    logic [2:0] rx_push_err;
    logic [15:0] divisor;
    int bad_count = 0, samples_checked = 0, st, ost, dl, i, x;

    umlsc_top DUT (.*);
    umlsc_peer u_peer (.*);

    always #5 clk = ~clk;
    ////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [7:0] e, g);
        samples_checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic bus(input bit wr, input int idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        address <= 6'(idx * 4);
        byteenable <= 4'hF;
        read <= !wr;
        write <= wr;
        writedata <= {24'h00_0000, d};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 40);
        if (n >= 40)
            chk("waitrequest", 8'h00, 8'h01);
        r = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task automatic rc(input string nm, input int idx, input logic [7:0] m, e);
        bus(1'b0, idx, 8'h00);
        chk(nm, e & m, r & m);
    endtask : rc

    task automatic pulse(input logic full, xo);
        @(posedge clk);
        rx_fifo_full <= full;
        rx_char_xonoff <= xo;
        rx_char_valid <= 1'b1;
        dd = 8'($urandom);
        rx_char_data <= dd;
        rx_char_parity_err <= 1'($urandom);
        rx_char_frame_err <= 1'($urandom);
        @(posedge clk);
        rx_char_valid <= 1'b0;
        rx_fifo_full <= 1'b0;
        @(posedge clk);
    endtask : pulse

    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        final_report();
    end

    initial
    begin
        void'($urandom(32'h2d1f_35d0));
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        rc("line format", 3, 8'hFF, 8'h1D);
        rc("scratch", 7, 8'hFF, 8'hFF);
        rc("modem control", 4, 8'hFF, 8'h00);
        chk("pins", 8'h03, {6'h00, term_ready_out_n, req_send_out_n});
        bus(1'b1, 4, 8'hE3);
        rc("locked bits", 4, 8'hFF, 8'h03);
        chk("pins low", 8'h00, {6'h00, term_ready_out_n, req_send_out_n});
        bus(1'b1, 8, 8'h10);
        bus(1'b1, 4, 8'hE3);
        rc("open bits", 4, 8'hFF, 8'hE3);
        chk("ir mode", 8'h01, {7'h00, ir_mode});
        bus(1'b1, 4, 8'hC7);
        bus(1'b1, 6, 8'h5A);
        bus(1'b1, 7, 8'hA5);
        rc("threshold", 6, 8'hFF, 8'h5A);
        chk("trigger", 8'hA5, fifo_trigger);
        bus(1'b1, 4, 8'h83);
        rc("scratch paged", 7, 8'hFF, 8'hFF);
        $display("test control done");
        bus(1'b1, 1, 8'h08);
        bus(1'b1, 8, 8'h90);
        bus(1'b1, 4, 8'h03);
        repeat (8) @(posedge clk);
        chk("halt", 8'h01, {7'h00, tx_halt});
        want <= 4'h1;
        repeat (8) @(posedge clk);
        chk("resume", 8'h00, {7'h00, tx_halt});
        st = 1;
        rc("modem state", 6, 8'hF0, 8'h10);
        for (i = 0; i < 12; i++)
        begin
            ost = st;
            st = $urandom % 16;
            slow <= 1'($urandom);
            want <= 4'(st);
            repeat (8) @(posedge clk);
            dl = ((st ^ ost) & 11) | (ost & ~st & 4);
            chk("irq", 8'(dl != 0), {7'h00, modem_irq_req});
            rc("changes", 6, 8'hFF, 8'(st * 16 + dl));
            rc("cleared", 6, 8'hFF, 8'(st * 16));
        end
        bus(1'b1, 4, 8'h1A);
        rc("loop state", 6, 8'hF0, 8'h90);
        chk("loop pins", 8'h03, {6'h00, term_ready_out_n, req_send_out_n});
        $display("test modem done");
        bus(1'b1, 3, 8'h9D);
        bus(1'b1, 0, 8'h34);
        bus(1'b1, 1, 8'h12);
        bus(1'b1, 3, 8'h1D);
        chk("divisor high", 8'h12, divisor[15:8]);
        chk("divisor low", 8'h34, divisor[7:0]);
        dd = 8'($urandom);
        bus(1'b1, 0, dd);
        bus(1'b0, 0, 8'h00);
        chk("load data", dd, tx_load_data);
        for (i = 0; i < 4; i++)
        begin
            rx_fifo_nonempty <= i[0];
            tx_shift_busy <= i[1];
            tx_fifo_empty <= i[0] ^ i[1];
            x = i[0] ^ i[1];
            rc("line state", 5, 8'h61, 8'(x * 32 + (x & ~i[1]) * 64 + i[0]));
        end
        $display("test status done");
        pulse(1'b1, 1'b0);
        rc("overrun", 5, 8'h02, 8'h02);
        rc("overrun clear", 5, 8'h02, 8'h00);
        bus(1'b1, 4, 8'h20);
        sw_flow_active <= 1'b1;
        for (i = 0; i < 6; i++)
        begin
            x = i % 2;
            pulse(1'b0, 1'(x));
            chk("resume pulse", 8'h01, {7'h00, xon_any_resume});
            chk("push", 8'(1 - x), {7'h00, rx_push});
            if (x == 0)
                chk("push data", dd, rx_push_data);
        end
        $display("test receive done");
        final_report();
    end
endmodule : tb

// ==== verif/umlsc_peer.sv ====
`timescale 1ns/1ns
module umlsc_peer
(
    input  wire logic       clk,
    input  wire logic       slow,
    input  wire logic [3:0] want,
    output logic            cts_in_n,
    output logic            set_ready_in_n,
    output logic            bell_indicator_in_n,
    output logic            carrier_detect_in_n
);
    // want: cts, set-ready, ring, carrier; 1 = pin low
    logic [3:0] pins_q = 4'hF;
    logic       ph_q   = 1'b0;
    // a slow peer moves only on every other edge, like polled firmware
    always_ff @(posedge clk)
    begin
        ph_q <= ~ph_q;
        if (!slow || ph_q)
            pins_q <= ~want;
    end
    assign cts_in_n            = pins_q[0];
    assign set_ready_in_n      = pins_q[1];
    assign bell_indicator_in_n = pins_q[2];
    assign carrier_detect_in_n = pins_q[3];
endmodule : umlsc_peer

// ==== verif/umlsc_sva.sv ====
`timescale 1ns/1ns
module umlsc_sva
(
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic [5:0]  address,
    input wire logic [3:0]  byteenable,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        term_ready_out_n,
    input wire logic        req_send_out_n,
    input wire logic        rx_char_valid,
    input wire logic        rx_char_parity_err,
    input wire logic        rx_char_frame_err,
    input wire logic        rx_char_break,
    input wire logic        rx_char_xonoff,
    input wire logic        rx_fifo_full,
    input wire logic        rx_fifo_nonempty,
    input wire logic        tx_fifo_empty,
    input wire logic        tx_shift_busy,
    input wire logic        rx_push,
    input wire logic [2:0]  rx_push_err,
    input wire logic        rx_pop,
    input wire logic        tx_load,
    input wire logic [7:0]  line_format,
    input wire logic [15:0] divisor,
    input wire logic        loopback,
    input wire logic        baud_tick
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire logic wr0 = write && !waitrequest && address == 6'h00 && byteenable[0];
    wire logic rd5 = read && waitrequest && address == 6'h14;

    a_data_load: assert property (
        wr0 && !line_format[7] |=> tx_load)
        else $error("no load pulse");
    a_div_load: assert property (
        wr0 && line_format[7] |=> !tx_load
        && divisor[7:0] == $past(writedata[7:0]))
        else $error("divisor write lost");
    a_data_pop: assert property (
        read && !waitrequest && address == 6'h00 && !line_format[7]
        |=> rx_pop)
        else $error("data read gave no pop");
    a_rx_ready: assert property (
        rd5 |=> readdata[0] == $past(rx_fifo_nonempty))
        else $error("data ready bit wrong");
    a_tx_idle: assert property (
        rd5 |=> readdata[6] == $past(tx_fifo_empty && !tx_shift_busy))
        else $error("idle bit wrong");
    a_ovr_drop: assert property (
        rx_char_valid && rx_fifo_full |=> !rx_push)
        else $error("character pushed into full fifo");
    a_push_tags: assert property (
        rx_char_valid && !rx_fifo_full && !rx_char_break && !rx_char_xonoff
        |=> rx_push && rx_push_err == $past({rx_char_break,
        rx_char_frame_err, rx_char_parity_err}))
        else $error("push or tags wrong");
    a_loop_pins: assert property (
        loopback && $past(loopback) |-> term_ready_out_n && req_send_out_n)
        else $error("pins driven in loopback");
    a_tick_gap: assert property (
        $fell(baud_tick) |-> ##[1:3] baud_tick)
        else $error("tick gap too long");
endmodule : umlsc_sva

bind umlsc_top umlsc_sva u_sva (.*);
